// file: rtl/mixed_fifo.sv
// Mixed-width FIFO, 4-bit writes and 8-bit reads, with per-side pointer
// reset selection and fill flags.
// Assumes one clock for both sides and synchronous user inputs.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps

module mixed_fifo
	import fifo_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// Side resets
	input wire logic i_wr_rst,
	input wire logic i_rd_rst,
	// Write side
	input wire logic i_wr_en,
	input wire logic [WR_WIDTH-1:0] i_wr_data,
	output logic o_full,
	output logic o_almost_full,
	output logic o_wr_err,
	// Read side
	input wire logic i_rd_en,
	output logic [RD_WIDTH-1:0] o_rd_data,
	output logic o_empty,
	output logic o_almost_empty,
	output logic o_rd_err
);

	typedef struct packed {
		logic [DEPTH_NIB-1:0][WR_WIDTH-1:0] mem;
		logic [5:0] wptr;
		logic [4:0] rptr;
		logic [RD_WIDTH-1:0] rd_data;
		logic rd_err;
		logic wr_err;
		logic [1:0] wr_mode;
		logic [1:0] rd_mode;
		logic [4:0] aempty_thr;
		logic [5:0] afull_thr;
		logic [31:0] rdata;
	} fifo_state_s;

	fifo_state_s state;
	fifo_state_s next_state;

	// Stored nibbles, write pointer minus twice the read pointer
	function automatic logic [5:0] fill_nib(input logic [5:0] w, input logic [4:0] r);
		fill_nib = w - {r, 1'b0};
	endfunction : fill_nib

	// ----------------------------------------
	// Reset selection per side
	// ----------------------------------------
	rst_sel_if wr_sel ();
	rst_sel_if rd_sel ();

	assign wr_sel.own_rst = i_wr_rst;
	assign wr_sel.other_rst = i_rd_rst;
	assign wr_sel.mode = state.wr_mode;
	assign rd_sel.own_rst = i_rd_rst;
	assign rd_sel.other_rst = i_wr_rst;
	assign rd_sel.mode = state.rd_mode;

	rst_select u_wr_sel (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.sel(wr_sel.sel)
	);

	rst_select u_rd_sel (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.sel(rd_sel.sel)
	);

	// ----------------------------------------
	// Flags
	// ----------------------------------------
	logic [5:0] fill;
	logic [4:0] words;
	logic [5:0] free;

	always_comb
	begin
		fill = fill_nib(state.wptr, state.rptr);
		words = fill[5:1];
		free = CAP_NIB - fill;
		o_empty = (words == 5'h00);
		o_almost_empty = (words <= state.aempty_thr);
		o_full = (free == 6'h00);
		o_almost_full = (free <= state.afull_thr);
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		next_state = state;
		next_state.rd_err = 1'b0;
		next_state.wr_err = 1'b0;
		next_state.rdata = 32'h0;

		// Write side
		if (wr_sel.ptr_rst)
			next_state.wptr = 6'h00;
		else if (i_wr_en)
		begin
			if (o_full)
				next_state.wr_err = 1'b1;
			else
			begin
				next_state.mem[state.wptr[4:0]] = i_wr_data;
				next_state.wptr = state.wptr + 6'h01;
			end
		end

		// Read side
		if (rd_sel.ptr_rst)
			next_state.rptr = 5'h00;
		else if (i_rd_en)
		begin
			if (o_empty)
				next_state.rd_err = 1'b1;
			else
			begin
				next_state.rd_data = {state.mem[{state.rptr[3:0], 1'b1}],
					state.mem[{state.rptr[3:0], 1'b0}]};
				next_state.rptr = state.rptr + 5'h01;
			end
		end

		// Register writes
		if (i_wr)
		begin
			case (i_addr)
				ADDR_CTRL:
				begin
					next_state.wr_mode = i_wdata[CTRL_WR_MODE_LSB +: 2];
					next_state.rd_mode = i_wdata[CTRL_RD_MODE_LSB +: 2];
				end
				ADDR_THRESH:
				begin
					next_state.aempty_thr = i_wdata[THR_AEMPTY_LSB +: 5];
					next_state.afull_thr = i_wdata[THR_AFULL_LSB +: 6];
				end
				default: ;
			endcase
		end

		// Register reads, data in the following cycle
		if (i_rd)
		begin
			case (i_addr)
				ADDR_CTRL:
				begin
					next_state.rdata[CTRL_WR_MODE_LSB +: 2] = state.wr_mode;
					next_state.rdata[CTRL_RD_MODE_LSB +: 2] = state.rd_mode;
				end
				ADDR_THRESH:
				begin
					next_state.rdata[THR_AEMPTY_LSB +: 5] = state.aempty_thr;
					next_state.rdata[THR_AFULL_LSB +: 6] = state.afull_thr;
				end
				ADDR_STATUS:
				begin
					next_state.rdata[ST_EMPTY_BIT] = o_empty;
					next_state.rdata[ST_AEMPTY_BIT] = o_almost_empty;
					next_state.rdata[ST_FULL_BIT] = o_full;
					next_state.rdata[ST_AFULL_BIT] = o_almost_full;
					next_state.rdata[ST_RD_ERR_BIT] = state.rd_err;
					next_state.rdata[ST_WR_ERR_BIT] = state.wr_err;
					next_state.rdata[ST_FILL_LSB +: 6] = fill;
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			state <= '0;
			state.wr_mode <= WR_MODE_RST;
			state.rd_mode <= RD_MODE_RST;
			state.aempty_thr <= AEMPTY_THR_RST;
			state.afull_thr <= AFULL_THR_RST;
		end
		else
			state <= next_state;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_rd_data = state.rd_data;
	assign o_rd_err = state.rd_err;
	assign o_wr_err = state.wr_err;
	assign o_rdata = state.rdata;

endmodule : mixed_fifo

// file: rtl/fifo_pkg.sv
// Constants and register map of the mixed-width FIFO.
// Assumes one clock for both FIFO sides and a plain register port.
// Behaviour
// - empty clears only once two 4-bit writes make one 8-bit word
// - low-fill flag clears only when complete words exceed the threshold
// - low-fill flag sets again once words drop to threshold or below
// - each 8-bit read joins the data of two consecutive 4-bit writes
// - empty holds while less than one read word is stored
// - read while empty is ignored, read error flag follows next cycle
// - empty sets after the last available word is read
// - internally synchronised reset takes two clock cycles to act
// - reset clears pointers, sets empty and low-fill, clears full flags
// - mode 2'b00, own reset input resets the side directly
// - mode 2'b01, opposite reset input resets the side directly
// - mode 2'b10, own reset ORed with synchronised opposite reset
// - mode 2'b11, synchronised opposite reset resets the side
// - write and read reset selection is set independently
// - pointers reset synchronously, behind the selection logic
// - with 2'b10 on both sides, either reset clears both pointers
// - full and high-fill flags count in write-width units

package fifo_pkg;

	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int WR_WIDTH = 4;
	localparam int RD_WIDTH = 8;
	localparam int DEPTH_NIB = 32;
	localparam logic [5:0] CAP_NIB = 6'h20;

	// ----------------------------------------
	// Reset selection modes
	// ----------------------------------------
	localparam logic [1:0] MODE_OWN = 2'h0;
	localparam logic [1:0] MODE_OTHER = 2'h1;
	localparam logic [1:0] MODE_OWN_OR_SYNC = 2'h2;
	localparam logic [1:0] MODE_SYNC_OTHER = 2'h3;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_THRESH = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;

	// CTRL fields
	localparam int CTRL_WR_MODE_LSB = 0;
	localparam int CTRL_RD_MODE_LSB = 2;
	localparam logic [1:0] WR_MODE_RST = 2'h3;
	localparam logic [1:0] RD_MODE_RST = 2'h3;

	// THRESH fields
	localparam int THR_AEMPTY_LSB = 0;
	localparam int THR_AFULL_LSB = 8;
	localparam logic [4:0] AEMPTY_THR_RST = 5'h03;
	localparam logic [5:0] AFULL_THR_RST = 6'h03;

	// STATUS fields
	localparam int ST_EMPTY_BIT = 0;
	localparam int ST_AEMPTY_BIT = 1;
	localparam int ST_FULL_BIT = 2;
	localparam int ST_AFULL_BIT = 3;
	localparam int ST_RD_ERR_BIT = 4;
	localparam int ST_WR_ERR_BIT = 5;
	localparam int ST_FILL_LSB = 8;

endpackage : fifo_pkg

// file: rtl/rst_sel_if.sv
// Interface between the FIFO core and one reset selector.
// Assumes all signals belong to the single FIFO clock.
`timescale 1ns/1ps

interface rst_sel_if;
	logic own_rst;
	logic other_rst;
	logic [1:0] mode;
	logic ptr_rst;

	modport sel (
		input own_rst,
		input other_rst,
		input mode,
		output ptr_rst
	);

	modport core (
		output own_rst,
		output other_rst,
		output mode,
		input ptr_rst
	);
endinterface : rst_sel_if

// file: rtl/rst_select.sv
// Pointer reset selector for one FIFO side.
// Assumes reset inputs are levels synchronous to i_clk.
`timescale 1ns/1ps

module rst_select
	import fifo_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Selection
	rst_sel_if.sel sel
);

	typedef struct packed {
		logic sync1;
		logic sync2;
	} sel_state_s;

	sel_state_s state;
	sel_state_s next_state;

	// ----------------------------------------
	// Two-stage synchroniser and mux
	// ----------------------------------------
	always_comb
	begin
		next_state = state;
		next_state.sync1 = sel.other_rst;
		next_state.sync2 = state.sync1;
		case (sel.mode)
			MODE_OWN: sel.ptr_rst = sel.own_rst;
			MODE_OTHER: sel.ptr_rst = sel.other_rst;
			MODE_OWN_OR_SYNC: sel.ptr_rst = sel.own_rst | state.sync2;
			MODE_SYNC_OTHER: sel.ptr_rst = state.sync2;
			default: sel.ptr_rst = state.sync2;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			state <= '0;
		else
			state <= next_state;
	end

endmodule : rst_select

// file: sim/fifo_props.sv
// Checker of the FIFO flag, data and error outputs.
// Bound to mixed_fifo; sees only its ports.
`timescale 1ns/1ps

module fifo_props
	import fifo_pkg::*;
(
	// Clock, reset and requests
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_wr_rst,
	input wire logic i_rd_rst,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	// Observed outputs
	input wire logic o_full,
	input wire logic o_almost_full,
	input wire logic o_wr_err,
	input wire logic [RD_WIDTH-1:0] o_rd_data,
	input wire logic o_empty,
	input wire logic o_almost_empty,
	input wire logic o_rd_err
);
	logic [1:0] rst_hist;
	logic quiet;

	// No direct or synced pointer reset can land next edge
	assign quiet = !(i_wr_rst | i_rd_rst) && (rst_hist == 2'h0);

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			rst_hist <= 2'h0;
		else
			rst_hist <= {rst_hist[0], i_wr_rst | i_rd_rst};
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	a_rderr_cause: assert property (o_rd_err |-> $past(i_rd_en && o_empty))
		else $error("read error without empty read");
	a_rderr_when_empty: assert property (i_rd_en && o_empty && quiet |=> o_rd_err)
		else $error("empty read gave no read error");
	a_empty_holds: assert property (!o_empty && !i_rd_en && quiet |=> !o_empty)
		else $error("empty rose without a read");
	a_aempty_holds: assert property (!o_almost_empty && !i_rd_en && quiet |=> !o_almost_empty)
		else $error("low-fill rose without a read");
	a_empty_low_fill: assert property (o_empty |-> o_almost_empty)
		else $error("empty without low-fill");
	a_rd_data_hold: assert property (!i_rd_en |=> $stable(o_rd_data))
		else $error("read data changed without a read");
	a_wrerr_cause: assert property (o_wr_err |-> $past(i_wr_en && o_full))
		else $error("write error without full write");
	a_full_flags: assert property (o_full |-> o_almost_full && !o_empty)
		else $error("full flag inconsistent");
	a_reset_flags: assert property ($rose(i_nrst) |-> o_empty && o_almost_empty && !o_full && !o_almost_full)
		else $error("flags wrong after reset");

	c_rd_err: cover property (o_rd_err);
	c_fill: cover property ($fell(o_almost_empty));
	c_drain: cover property ($rose(o_empty));
endmodule : fifo_props

// file: sim/fifo_user.sv
// Model of the user logic on the FIFO write and read ports.
// Assumes the bench asks for writes and reads by level.
`timescale 1ns/1ps

module fifo_user
	import fifo_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Bench requests
	input wire logic i_wr_go,
	input wire logic i_rd_go,
	// FIFO side
	output logic o_wr_en,
	output logic [WR_WIDTH-1:0] o_wr_data,
	output logic o_rd_en
);
	logic [1:0] settle;
	logic [WR_WIDTH-1:0] nib;
	logic ready;

	assign ready = settle == 2'h3;
	assign o_wr_en = i_wr_go & ready;
	assign o_rd_en = i_rd_go & ready;
	// Idle data line shows the inverted next nibble
	assign o_wr_data = o_wr_en ? nib : ~nib;

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			settle <= 2'h0;
			nib <= '0;
		end
		else
		begin
			settle <= ready ? settle : settle + 2'h1;
			nib <= o_wr_en ? nib + 4'h1 : nib;
		end
	end
endmodule : fifo_user

// file: sim/mixed_fifo_bench.sv
// Self-checking bench of the mixed-width FIFO.
// Assumes fifo_user drives the data ports and fifo_props is bound.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (b)); end end

module mixed_fifo_bench
	import fifo_pkg::*;
;
	logic i_clk, i_nrst, i_wr, i_rd, i_wr_rst, i_rd_rst, wr_go, rd_go, wr_en, rd_en;
	logic [7:0] i_addr;
	logic [31:0] i_wdata, o_rdata;
	logic [WR_WIDTH-1:0] wr_data;
	logic [RD_WIDTH-1:0] o_rd_data;
	logic o_full, o_almost_full, o_wr_err, o_empty, o_almost_empty, o_rd_err;
	int n_mismatch, samples_checked;

	mixed_fifo uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_wr_rst(i_wr_rst), .i_rd_rst(i_rd_rst),
		.i_wr_en(wr_en), .i_wr_data(wr_data), .o_full(o_full), .o_almost_full(o_almost_full),
		.o_wr_err(o_wr_err), .i_rd_en(rd_en), .o_rd_data(o_rd_data), .o_empty(o_empty),
		.o_almost_empty(o_almost_empty), .o_rd_err(o_rd_err));
	fifo_user user (.i_clk(i_clk), .i_nrst(i_nrst), .i_wr_go(wr_go), .i_rd_go(rd_go),
		.o_wr_en(wr_en), .o_wr_data(wr_data), .o_rd_en(rd_en));

	always #50 i_clk = ~i_clk;

	task results;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	task do_reset;
		@(posedge i_clk) i_nrst <= 1'b0;
		repeat (6) @(posedge i_clk);
		i_nrst <= 1'b1;
		repeat (4) @(posedge i_clk);
	endtask : do_reset

	task reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk) i_wr <= 1'b0;
	endtask : reg_wr

	task reg_rd(input logic [7:0] a, input logic [31:0] x);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk) i_rd <= 1'b0;
		@(negedge i_clk) `CHK(o_rdata, x);
	endtask : reg_rd

	task push(input int n);
		@(posedge i_clk) wr_go <= 1'b1;
		repeat (n) @(posedge i_clk);
		wr_go <= 1'b0;
		@(negedge i_clk);
	endtask : push

	task pop(input logic err, input logic [7:0] d);
		@(posedge i_clk) rd_go <= 1'b1;
		@(posedge i_clk) rd_go <= 1'b0;
		@(negedge i_clk) `CHK(o_rd_err, err);
		`CHK(o_rd_data, d);
	endtask : pop

	// Pointer reset with a same-cycle write and one write after, empty seen 1, 2, 3 edges on
	task rst_case(input logic [3:0] c, input logic w, input logic r, input logic e1,
		input logic e3);
		reg_wr(ADDR_CTRL, {28'h0, c});
		push(4);
		@(posedge i_clk);
		i_wr_rst <= w;
		i_rd_rst <= r;
		wr_go <= 1'b1;
		@(posedge i_clk);
		i_wr_rst <= 1'b0;
		i_rd_rst <= 1'b0;
		@(negedge i_clk) `CHK(o_empty, e1);
		@(posedge i_clk) wr_go <= 1'b0;
		@(negedge i_clk) `CHK(o_empty, e1);
		@(posedge i_clk);
		@(negedge i_clk) `CHK(o_empty, e3);
	endtask : rst_case

	initial
	begin
		{i_clk, i_nrst, i_wr, i_rd, i_wr_rst, i_rd_rst, wr_go, rd_go} = '0;
		i_addr = 8'h00;
		i_wdata = 32'h0;
		n_mismatch = 0;
		samples_checked = 0;
		do_reset();
		reg_rd(ADDR_STATUS, 32'h3);
		reg_rd(ADDR_CTRL, 32'hf);
		for (int i = 1; i <= 8; i++)
		begin
			push(1);
			`CHK(o_empty, i < 2);
			`CHK(o_almost_empty, i < 8);
		end
		for (int i = 0; i < 4; i++)
		begin
			pop(1'b0, 8'(i * 34 + 16));
			`CHK(o_almost_empty, 1'b1);
		end
		`CHK(o_empty, 1'b1);
		pop(1'b1, 8'h76);
		push(3);
		pop(1'b0, 8'h98);
		`CHK(o_empty, 1'b1);
		pop(1'b1, 8'h98);
		push(27);
		`CHK(o_almost_full, 1'b0);
		push(1);
		`CHK(o_almost_full, 1'b1);
		`CHK(o_full, 1'b0);
		push(3);
		`CHK(o_full, 1'b1);
		push(1);
		`CHK(o_wr_err, 1'b1);
		do_reset();
		rst_case(4'h0, 1'b1, 1'b1, 1'b1, 1'b1);
		rst_case(4'h0, 1'b0, 1'b1, 1'b0, 1'b0);
		rst_case(4'h1, 1'b0, 1'b1, 1'b1, 1'b1);
		rst_case(4'ha, 1'b0, 1'b1, 1'b0, 1'b1);
		rst_case(4'hc, 1'b1, 1'b0, 1'b1, 1'b1);
		rst_case(4'hf, 1'b1, 1'b1, 1'b0, 1'b1);
		results();
	end

	initial
	begin
		repeat (1000) @(posedge i_clk);
		n_mismatch++;
		results();
	end
endmodule : mixed_fifo_bench

bind mixed_fifo fifo_props props (.i_clk(i_clk), .i_nrst(i_nrst), .i_wr_rst(i_wr_rst),
	.i_rd_rst(i_rd_rst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_full(o_full),
	.o_almost_full(o_almost_full), .o_wr_err(o_wr_err), .o_rd_data(o_rd_data),
	.o_empty(o_empty), .o_almost_empty(o_almost_empty), .o_rd_err(o_rd_err));
